// >>> common/radio_host_params.svh
`ifndef RADIO_HOST_PARAMS_SVH
`define RADIO_HOST_PARAMS_SVH
`define FIFO_ADDR        8'hFF
`define HDR_CMD_BIT      7
`define HDR_READ_BIT     0
`define SEL_LSB          3
`define SEL_MSB          7
`define MODE_LSB         0
`define MODE_MSB         1
`define GPIO0_CONF_RST   8'h0A
`define GPIOX_CONF_RST   8'hA2
`define EVT_WKUP_TOUT    15
`define EVT_READY        16
`define EVT_MASK_RST     32'h0000_0000
`define EXT_CLK_NOM_HZ   34700
`endif

// >>> common/radio_host_pkg.sv
package radio_host_pkg;
	typedef enum logic [1:0] {
		HDR_PHASE  = 2'b00,
		ADDR_PHASE = 2'b01,
		DATA_PHASE = 2'b10,
		IGNORE     = 2'b11
	} spi_phase_t;
	typedef enum logic [1:0] {
		PIN_ANALOG  = 2'b00,
		PIN_DIG_IN  = 2'b01,
		PIN_OUT_LP  = 2'b10,
		PIN_OUT_HP  = 2'b11
	} pin_mode_t;
endpackage : radio_host_pkg

// >>> hdl/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("byte_fifo: depth must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	logic             push;
	logic             pop;
	assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign out_valid = wr_r != rd_r;
	assign out_data  = mem_r[rd_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge clock) begin
		if (push)
			mem_r[wr_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// >>> hdl/radio_host_spi_irq_gpio.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_host_params.svh"
module radio_host_spi_irq_gpio #(
	parameter int NPINS      = 4,
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// serial link from host
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso_o,
	output logic             miso_oe_n,
	// register file port
	output logic             reg_we,
	output logic             reg_re,
	output logic [7:0]       reg_addr,
	output logic [7:0]       reg_wdata,
	input  wire logic [7:0]  reg_rdata,
	output logic             cmd_valid,
	output logic [7:0]       cmd_code,
	// fifos
	output logic             txf_valid,
	input  wire logic        txf_ready,
	output logic [7:0]       txf_data,
	input  wire logic        rxf_valid,
	output logic             rxf_ready,
	input  wire logic [7:0]  rxf_data,
	// status and events
	input  wire logic [15:0] machine_state_status,
	input  wire logic [31:0] event_pulse,
	input  wire logic        crystal_oscillator_ready,
	input  wire logic        ready_state,
	input  wire logic [31:0] event_mask,
	input  wire logic        status_read,
	output logic [31:0]      event_status,
	output logic             event_request_n,
	// signals for pins
	input  wire logic [31:0] pin_sources,
	input  wire logic [7:0]  pin_conf_in [NPINS],
	input  wire logic        pin_conf_we [NPINS],
	input  wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_o,
	output logic [NPINS-1:0] pin_oe_n,
	output logic [NPINS-1:0] pin_hp,
	output logic             tx_start,
	output logic             rx_start,
	output logic             tx_mod_data,
	output logic             ext_wakeup,
	output logic             low_duty_receive_clk
);
	import radio_host_pkg::*;
	initial begin
		if (NPINS < 1 || NPINS > 8)
			$error("pin count out of range");
	end
	// link input synchronisers, three stages
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [2:0] mosi_s;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sclk_s <= 3'h0;
			cs_s   <= 3'h7;
			mosi_s <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			cs_s   <= {cs_s[1:0], cs_n};
			mosi_s <= {mosi_s[1:0], mosi};
		end
	end
	logic sclk_rise;
	logic sclk_fall;
	logic cs_low;
	logic cs_rise;
	logic cs_fall;
	assign sclk_rise = sclk_s[1] && !sclk_s[2];
	assign sclk_fall = !sclk_s[1] && sclk_s[2];
	assign cs_low    = !cs_s[1] && !cs_s[2];
	assign cs_rise   = cs_s[1] && !cs_s[2];
	assign cs_fall   = !cs_s[1] && cs_s[2];
	// serial engine; runs regardless of power state
	spi_phase_t phase_r;
	logic [2:0] bit_r;
	logic [6:0] rx_sh_r;
	logic [7:0] tx_sh_r;
	logic       is_read_r;
	logic       is_cmd_r;
	logic [7:0] addr_r;
	logic       hdr_byte_r;
	logic       pend_cmd_r;
	logic [7:0] pend_code_r;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic [7:0] rd_byte;
	assign rx_byte   = {rx_sh_r, mosi_s[2]};
	assign byte_done = cs_low && sclk_rise && bit_r == 3'h7;
	assign rd_byte   = (addr_r == `FIFO_ADDR) ? rxf_data : reg_rdata;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase_r    <= HDR_PHASE;
			bit_r      <= 3'h0;
			rx_sh_r    <= 7'h00;
			is_read_r  <= 1'b0;
			is_cmd_r   <= 1'b0;
			addr_r     <= 8'h00;
			hdr_byte_r <= 1'b0;
		end else if (!cs_low) begin
			phase_r    <= HDR_PHASE;
			bit_r      <= 3'h0;
			hdr_byte_r <= 1'b0;
		end else if (sclk_rise) begin
			rx_sh_r <= {rx_sh_r[5:0], mosi_s[2]};
			bit_r   <= bit_r + 3'h1;
			if (bit_r == 3'h7) begin
				unique case (phase_r)
					HDR_PHASE: begin
						if (rx_byte[6:1] != 6'h00) begin
							phase_r <= IGNORE;
						end else begin
							is_cmd_r  <= rx_byte[`HDR_CMD_BIT];
							is_read_r <= rx_byte[`HDR_READ_BIT];
							phase_r   <= ADDR_PHASE;
						end
						hdr_byte_r <= 1'b1;
					end
					ADDR_PHASE: begin
						addr_r     <= rx_byte;
						hdr_byte_r <= 1'b0;
						phase_r    <= is_cmd_r ? IGNORE : DATA_PHASE;
					end
					DATA_PHASE: begin
						if (addr_r != `FIFO_ADDR)
							addr_r <= addr_r + 8'h01;
					end
					IGNORE: begin
						phase_r <= IGNORE;
					end
				endcase
			end
		end
	end
	// command held until chip select rises
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pend_cmd_r  <= 1'b0;
			pend_code_r <= 8'h00;
			cmd_valid   <= 1'b0;
			cmd_code    <= 8'h00;
		end else begin
			cmd_valid <= 1'b0;
			if (cs_fall)
				pend_cmd_r <= 1'b0;
			if (byte_done && phase_r == ADDR_PHASE && is_cmd_r) begin
				pend_cmd_r  <= 1'b1;
				pend_code_r <= rx_byte;
			end
			if (cs_rise && pend_cmd_r) begin
				cmd_valid  <= 1'b1;
				cmd_code   <= pend_code_r;
				pend_cmd_r <= 1'b0;
			end
		end
	end
	// register writes, reads and fifo pushes/pops
	logic load_rd;
	assign load_rd = byte_done && !is_cmd_r && is_read_r
		&& (phase_r == ADDR_PHASE || phase_r == DATA_PHASE);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_we    <= 1'b0;
			reg_re    <= 1'b0;
			reg_addr  <= 8'h00;
			reg_wdata <= 8'h00;
			txf_valid <= 1'b0;
			txf_data  <= 8'h00;
			rxf_ready <= 1'b0;
		end else begin
			reg_we    <= 1'b0;
			reg_re    <= 1'b0;
			rxf_ready <= 1'b0;
			if (txf_valid && txf_ready)
				txf_valid <= 1'b0;
			if (byte_done && phase_r == DATA_PHASE && !is_read_r) begin
				if (addr_r == `FIFO_ADDR) begin
					txf_valid <= 1'b1;
					txf_data  <= rx_byte;
				end else begin
					reg_we    <= 1'b1;
					reg_addr  <= addr_r;
					reg_wdata <= rx_byte;
				end
			end else if (byte_done && phase_r == ADDR_PHASE && !is_cmd_r) begin
				reg_addr <= rx_byte;
				reg_re   <= is_read_r && rx_byte != `FIFO_ADDR;
			end else if (byte_done && phase_r == DATA_PHASE && is_read_r) begin
				if (addr_r == `FIFO_ADDR)
					rxf_ready <= rxf_valid;
				else begin
					reg_addr <= addr_r + 8'h01;
					reg_re   <= 1'b1;
				end
			end
		end
	end
	// output shifter: status during header and address bytes, then read data
	logic load_pend_r;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_sh_r     <= 8'h00;
			load_pend_r <= 1'b0;
		end else if (cs_fall) begin
			tx_sh_r     <= machine_state_status[15:8];
			load_pend_r <= 1'b0;
		end else if (byte_done && phase_r == HDR_PHASE) begin
			tx_sh_r <= machine_state_status[7:0];
		end else if (load_rd) begin
			load_pend_r <= 1'b1;
		end else if (load_pend_r) begin
			tx_sh_r     <= rd_byte;
			load_pend_r <= 1'b0;
		end else if (cs_low && sclk_fall && bit_r != 3'h0) begin
			tx_sh_r <= {tx_sh_r[6:0], 1'b0};
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			miso_o    <= 1'b0;
			miso_oe_n <= 1'b1;
		end else begin
			miso_oe_n <= !cs_low;
			miso_o    <= cs_low ? tx_sh_r[7] : 1'b0;
		end
	end
	// event flags
	logic [31:0] evt_set;
	logic [31:0] evt_next;
	logic [31:0] evt_valid;
	logic        ready_d_r;
	logic        wkup_pend_r;
	assign evt_valid = 32'h300F_FFFF;
	always_comb begin
		evt_set = event_pulse & evt_valid;
		evt_set[`EVT_WKUP_TOUT] = (event_pulse[`EVT_WKUP_TOUT] || wkup_pend_r)
			&& crystal_oscillator_ready;
		evt_set[`EVT_READY] = ready_state && !ready_d_r && crystal_oscillator_ready;
		// set wins over read clear
		evt_next = (status_read ? 32'h0000_0000 : event_status) | evt_set;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ready_d_r       <= 1'b0;
			wkup_pend_r     <= 1'b0;
			event_status    <= 32'h0000_0000;
			event_request_n <= 1'b1;
		end else begin
			ready_d_r <= ready_state;
			// expiry seen before the crystal runs is held until it does
			wkup_pend_r <= (wkup_pend_r || event_pulse[`EVT_WKUP_TOUT])
				&& !crystal_oscillator_ready;
			event_status    <= evt_next;
			event_request_n <= (evt_next & event_mask) == 32'h0000_0000;
		end
	end
	// pin function selection
	logic [7:0] conf_r [NPINS];
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			logic [4:0] sel;
			pin_mode_t  mode;
			logic       out_v;
			assign sel  = conf_r[g][`SEL_MSB:`SEL_LSB];
			assign mode = pin_mode_t'(conf_r[g][`MODE_MSB:`MODE_LSB]);
			always_comb begin
				unique case (sel)
					5'h00:   out_v = event_request_n;
					5'h13:   out_v = 1'b1;
					5'h14:   out_v = 1'b0;
					5'h11,
					5'h1F:   out_v = 1'b0;
					default: out_v = pin_sources[sel];
				endcase
			end
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n)
					conf_r[g] <= (g == 0) ? `GPIO0_CONF_RST : `GPIOX_CONF_RST;
				else if (pin_conf_we[g])
					conf_r[g] <= pin_conf_in[g];
			end
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					pin_o[g]    <= 1'b0;
					pin_oe_n[g] <= 1'b1;
					pin_hp[g]   <= 1'b0;
				end else begin
					pin_o[g]    <= out_v;
					pin_oe_n[g] <= !(mode == PIN_OUT_LP || mode == PIN_OUT_HP);
					pin_hp[g]   <= mode == PIN_OUT_HP;
				end
			end
		end
	endgenerate
	// input functions from pins in input mode
	logic [NPINS-1:0] in_s1_r;
	logic [NPINS-1:0] in_s2_r;
	logic [NPINS-1:0] in_s3_r;
	logic [4:0]       in_hit;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_s1_r <= '0;
			in_s2_r <= '0;
			in_s3_r <= '0;
		end else begin
			in_s1_r <= pin_in;
			in_s2_r <= in_s1_r;
			in_s3_r <= in_s2_r;
		end
	end
	always_comb begin
		in_hit = 5'h00;
		for (int i = 0; i < NPINS; i++) begin
			if (conf_r[i][`MODE_MSB:`MODE_LSB] == PIN_DIG_IN
				&& conf_r[i][`SEL_MSB:`SEL_LSB] < 5'h05
				&& in_s2_r[i] && in_s3_r[i])
				in_hit[conf_r[i][`SEL_LSB+2:`SEL_LSB]] = 1'b1;
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_start             <= 1'b0;
			rx_start             <= 1'b0;
			tx_mod_data          <= 1'b0;
			ext_wakeup           <= 1'b0;
			low_duty_receive_clk <= 1'b0;
		end else begin
			tx_start             <= in_hit[0];
			rx_start             <= in_hit[1];
			tx_mod_data          <= in_hit[2];
			ext_wakeup           <= in_hit[3];
			low_duty_receive_clk <= in_hit[4];
		end
	end
endmodule : radio_host_spi_irq_gpio
`default_nettype wire

// >>> dv/radio_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module radio_host_chk (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        cs_n,
	input wire logic        miso_oe_n,
	input wire logic        cmd_valid,
	input wire logic [31:0] event_pulse,
	input wire logic        crystal_oscillator_ready,
	input wire logic        ready_state,
	input wire logic [31:0] event_mask,
	input wire logic        status_read,
	input wire logic [31:0] event_status,
	input wire logic        event_request_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic pend;
	assign pend = |(event_status & event_mask);
	sequence s_cs_up;
		$rose(cs_n) ##1 cs_n [*3];
	endsequence
	sequence s_cmd_once;
		cmd_valid ##1 !cmd_valid;
	endsequence
	property p_release; s_cs_up |-> ##[0:4] miso_oe_n; endproperty
	property p_idle; cs_n [*8] |-> miso_oe_n; endproperty
	property p_req_on; pend [*2] |-> !event_request_n; endproperty
	property p_req_off; !pend [*2] |-> event_request_n; endproperty
	property p_set; event_pulse[2] |=> event_status[2]; endproperty
	property p_hold; event_status[2] && !status_read |=> event_status[2]; endproperty
	property p_clear;
		status_read && event_pulse == 32'h0000_0000 |=> event_status[14:0] == 15'h0000;
	endproperty
	property p_wkup;
		$rose(event_status[15]) |-> crystal_oscillator_ready || $past(crystal_oscillator_ready);
	endproperty
	property p_ready;
		$rose(event_status[16]) |-> crystal_oscillator_ready && (ready_state || $past(ready_state));
	endproperty
	property p_cmd; cmd_valid |-> cs_n ##0 s_cmd_once; endproperty
	a_release: assert property (p_release) else $error("output not released after deselect");
	a_idle: assert property (p_idle) else $error("output driven while deselected");
	a_req_on: assert property (p_req_on) else $error("request missing");
	a_req_off: assert property (p_req_off) else $error("request without unmasked flag");
	a_set: assert property (p_set) else $error("event flag not set");
	a_hold: assert property (p_hold) else $error("flag lost before read");
	a_clear: assert property (p_clear) else $error("flags not cleared by read");
	a_wkup: assert property (p_wkup) else $error("wake flag without crystal");
	a_ready: assert property (p_ready) else $error("ready flag without cause");
	a_cmd: assert property (p_cmd) else $error("command while selected");
endmodule : radio_host_chk
bind radio_host_spi_irq_gpio radio_host_chk i_radio_host_chk (.clock, .reset_n, .cs_n,
	.miso_oe_n, .cmd_valid, .event_pulse, .crystal_oscillator_ready, .ready_state,
	.event_mask, .status_read, .event_status, .event_request_n);
`default_nettype wire

// >>> dv/host_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module host_spi_master (
	input  wire logic clock,
	input  wire logic miso,
	output var logic  sclk,
	output var logic  cs_n,
	output var logic  mosi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic sel();
		@(negedge clock) cs_n = 1'b0;
		repeat (4) @(negedge clock);
	endtask : sel
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			mosi = d[i];
			repeat (4) @(negedge clock);
			// taken at the rising edge, while the bit still stands
			q[i] = miso;
			sclk = 1'b1;
			repeat (4) @(negedge clock);
			sclk = 1'b0;
		end
	endtask : xbyte
	task automatic desel();
		repeat (4) @(negedge clock);
		cs_n = 1'b1;
		repeat (12) @(negedge clock);
	endtask : desel
endmodule : host_spi_master
`default_nettype wire

// >>> dv/tb_radio_host_spi_irq_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module tb_radio_host_spi_irq_gpio;
	logic clock, reset_n, sclk, cs_n, mosi, miso_o, miso_oe_n, miso_w, miso_last;
	logic reg_we, reg_re, cmd_valid, txf_valid, txf_ready, rxf_valid, rxf_ready;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_code, txf_data, rxf_data, q, cmd_seen;
	logic [15:0] mstat;
	logic [31:0] event_pulse, event_mask, event_status, pin_sources;
	logic xo_rdy, ready_state, status_read, event_request_n, fo_valid, fo_ready;
	logic [7:0] pin_conf_in [4];
	logic pin_conf_we [4];
	logic [3:0] pin_in, pin_o, pin_oe_n, pin_hp;
	logic [4:0] fn;
	logic [7:0] fo_data, wa[$], wd[$];
	int n_fail, tests_run, cyc, n_re;
	radio_host_spi_irq_gpio i_radio_host_spi_irq_gpio (.clock, .reset_n, .sclk, .cs_n, .mosi,
		.miso_o, .miso_oe_n, .reg_we, .reg_re, .reg_addr, .reg_wdata, .reg_rdata, .cmd_valid,
		.cmd_code, .txf_valid, .txf_ready, .txf_data, .rxf_valid, .rxf_ready, .rxf_data,
		.machine_state_status(mstat), .event_pulse, .crystal_oscillator_ready(xo_rdy),
		.ready_state, .event_mask, .status_read, .event_status, .event_request_n,
		.pin_sources, .pin_conf_in, .pin_conf_we, .pin_in, .pin_o, .pin_oe_n, .pin_hp,
		.tx_start(fn[0]), .rx_start(fn[1]), .tx_mod_data(fn[2]), .ext_wakeup(fn[3]),
		.low_duty_receive_clk(fn[4]));
	host_spi_master i_host_spi_master (.clock, .miso(miso_w), .sclk, .cs_n, .mosi);
	byte_fifo #(.WIDTH(8), .DEPTH(32)) i_byte_fifo (.clock, .reset_n, .in_valid(txf_valid),
		.in_ready(txf_ready), .in_data(txf_data), .out_valid(fo_valid), .out_ready(fo_ready),
		.out_data(fo_data));
	// released line shows the inverse of its last driven bit
	assign miso_w = miso_oe_n ? ~miso_last : miso_o;
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (!miso_oe_n) miso_last <= miso_o;
		if (cmd_valid) cmd_seen <= cmd_code;
		if (reg_re) n_re++;
		if (reg_we) begin
			wa.push_back(reg_addr);
			wd.push_back(reg_wdata);
		end
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			wrap_up();
		end
	end
	always @(negedge clock) begin
		reg_rdata <= reg_addr ^ 8'h3C;
		if (rxf_ready) rxf_data <= rxf_data + 8'h01;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk
	task automatic xb(input logic [7:0] d);
		i_host_spi_master.xbyte(d, q);
	endtask : xb
	task automatic pulse(input int b);
		event_pulse = 32'h0000_0001 << b;
		@(negedge clock) event_pulse = 32'h0000_0000;
		repeat (3) @(negedge clock);
	endtask : pulse
	task automatic rd_clr();
		status_read = 1'b1;
		@(negedge clock) status_read = 1'b0;
		repeat (3) @(negedge clock);
	endtask : rd_clr
	task automatic conf(input int p, input logic [7:0] v);
		pin_conf_in[p] = v;
		pin_conf_we[p] = 1'b1;
		@(negedge clock) pin_conf_we[p] = 1'b0;
		repeat (6) @(negedge clock);
	endtask : conf
	task automatic t_read();
		i_host_spi_master.sel();
		xb(8'h01);
		chk(q, mstat[15:8], "status hi");
		xb(8'h20);
		chk(q, mstat[7:0], "status lo");
		xb(8'h00);
		chk(q, 8'h1C, "rd0");
		xb(8'h00);
		chk(q, 8'h1D, "rd1");
		i_host_spi_master.desel();
		$display("t_read done");
	endtask : t_read
	task automatic t_write();
		wa.delete();
		wd.delete();
		i_host_spi_master.sel();
		xb(8'h02);
		xb(8'h10);
		xb(8'hEE);
		i_host_spi_master.desel();
		chk(wa.size(), 0, "bad header wrote");
		i_host_spi_master.sel();
		xb(8'h00);
		xb(8'h10);
		xb(8'h5A);
		xb(8'hC3);
		i_host_spi_master.desel();
		chk(wa.size(), 2, "writes");
		chk({wa[0], wa[1], wd[0], wd[1]}, 32'h1011_5AC3, "burst");
		i_host_spi_master.sel();
		xb(8'h80);
		xb(8'h63);
		i_host_spi_master.desel();
		chk(cmd_seen, 8'h63, "cmd");
		$display("t_write done");
	endtask : t_write
	task automatic t_fifo();
		int w;
		fo_ready = 1'b0;
		i_host_spi_master.sel();
		xb(8'h00);
		xb(8'hFF);
		for (int i = 0; i < 33; i++) xb(8'h80 + 8'(i));
		i_host_spi_master.desel();
		chk({txf_valid, txf_ready}, 2'b10, "full stall");
		fo_ready = 1'b1;
		for (int i = 0; i < 33; i++) begin
			w = 0;
			while (fo_valid !== 1'b1 && w < 40) begin
				@(negedge clock);
				w++;
			end
			chk(fo_data, 8'h80 + 8'(i), "tx byte");
			@(negedge clock);
		end
		chk(fo_valid, 1'b0, "empty");
		w = n_re;
		i_host_spi_master.sel();
		xb(8'h01);
		xb(8'hFF);
		xb(8'h00);
		chk(q, 8'h40, "rx0");
		xb(8'h00);
		chk(q, 8'h41, "rx1");
		i_host_spi_master.desel();
		chk(n_re - w, 0, "fifo read hit registers");
		chk(rxf_data, 8'h42, "rx pops");
		$display("t_fifo done");
	endtask : t_fifo
	task automatic t_irq();
		event_mask = 32'h0000_0004;
		pulse(2);
		chk({event_status[2], event_request_n}, 2'b10, "raise");
		rd_clr();
		chk(event_status, 32'h0000_0000, "clear");
		chk(event_request_n, 1'b1, "release");
		pulse(5);
		pulse(29);
		chk({event_status[29], event_status[5], event_request_n}, 3'b111, "masked");
		rd_clr();
		pulse(15);
		chk(event_status[15], 1'b0, "wake early");
		xo_rdy = 1'b1;
		repeat (4) @(negedge clock);
		chk(event_status[15], 1'b1, "wake late");
		ready_state = 1'b1;
		repeat (4) @(negedge clock);
		chk(event_status[16], 1'b1, "ready");
		rd_clr();
		$display("t_irq done");
	endtask : t_irq
	task automatic t_pins();
		conf(1, {5'd19, 3'b010});
		chk({pin_o[1], pin_oe_n[1], pin_hp[1]}, 3'b100, "vdd");
		conf(1, {5'd20, 3'b011});
		chk({pin_o[1], pin_oe_n[1], pin_hp[1]}, 3'b001, "gnd");
		pin_sources = 32'h0000_0004;
		conf(1, {5'd2, 3'b010});
		chk(pin_o[1], 1'b1, "timer out");
		pin_sources = 32'h0000_0400;
		conf(1, {5'd10, 3'b010});
		chk(pin_o[1], 1'b1, "rx state");
		pin_sources = 32'hFFFF_FFFF;
		conf(1, {5'd17, 3'b010});
		chk(pin_o[1], 1'b0, "reserved");
		conf(1, {5'd2, 3'b000});
		chk(pin_oe_n[1], 1'b1, "analog");
		pin_in = 4'h4;
		for (int c = 0; c < 5; c++) begin
			conf(2, {5'(c), 3'b001});
			chk({pin_oe_n[2], fn}, {1'b1, 5'h01 << c}, "input fn");
		end
		$display("t_pins done");
	endtask : t_pins
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		{reset_n, event_pulse, event_mask, xo_rdy, ready_state, status_read} = '0;
		{pin_sources, pin_in, rxf_valid, fo_ready, cyc, n_fail, tests_run, n_re} = '0;
		{miso_last, reg_rdata, cmd_seen} = '0;
		mstat = 16'hA53C;
		rxf_data = 8'h40;
		for (int p = 0; p < 4; p++) {pin_conf_in[p], pin_conf_we[p]} = '0;
		repeat (8) @(negedge clock);
		reset_n = 1'b1;
		rxf_valid = 1'b1;
		repeat (4) @(negedge clock);
		t_read();
		t_write();
		t_fifo();
		t_irq();
		t_pins();
		wrap_up();
	end
endmodule : tb_radio_host_spi_irq_gpio
`default_nettype wire
